// *** verilog/pwm_pkg.sv ***
package pwm_pkg;

	// register map, byte addresses: group in paddr[7:5], index in [4:2]
	localparam int           ADDR_W   = 12;
	localparam int           GRP_LSB  = 5;
	localparam int           IDX_LSB  = 2;
	localparam logic [2:0]   GRP_CTRL = 3'h0;
	localparam logic [2:0]   GRP_CNT  = 3'h1;
	localparam logic [2:0]   GRP_PER  = 3'h2;
	localparam logic [2:0]   GRP_DTY  = 3'h3;
	localparam logic [2:0]   GRP_JCNT = 3'h4;

	// control group word indexes
	localparam logic [2:0]   C_ENABLE = 3'h0;
	localparam logic [2:0]   C_POLAR  = 3'h1;
	localparam logic [2:0]   C_CLKSEL = 3'h2;
	localparam logic [2:0]   C_ALIGN  = 3'h3;
	localparam logic [2:0]   C_JOIN   = 3'h4;
	localparam logic [2:0]   C_PRESC  = 3'h5;
	localparam logic [2:0]   C_SHDN   = 3'h6;

	// shutdown word fields
	localparam int           SD_IE    = 0;
	localparam int           SD_FLAG  = 1;
	localparam int           SD_CH7EN = 2;
	localparam int           SD_ACT   = 3;
	localparam int           SD_MODEN = 4;
	localparam int           SD_WSTOP = 5;
	localparam int           SD_PIN   = 6;
	localparam int           SD_LVL   = 8;

	// prescaler word fields
	localparam int           PRE_A    = 0;
	localparam int           PRE_B    = 8;

	localparam logic         DIR_UP   = 1'b0;
	localparam logic         DIR_DN   = 1'b1;
	localparam logic [7:0]   RST_BYTE = 8'h00;
	localparam logic [15:0]  ZERO16   = 16'h0000;
	localparam logic [15:0]  ONE16    = 16'h0001;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic [31:0]       wdata;
	} apb_req_s;

	typedef struct packed {
		logic       irq_en;
		logic       ch7_en;
		logic       act_lvl;
		logic       mod_en;
		logic       wait_stop;
		logic [7:0] level;
	} shdn_ctl_s;

endpackage : pwm_pkg

// *** verilog/pwm_pair_timer.sv ***
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Overview of operation
// (R01) eight 8-bit or four 16-bit channels
// (R02) four join bits fuse channel pairs
// (R03) even channel is high byte when joined
// (R04) joined clock from odd channel select
// (R05) joined output on odd pin, odd polarity
// (R06) odd enable only; even output disabled
// (R07) any joined counter write clears 16 bits
// (R08) software reads joined counter in one access
// (R09) odd align bit selects joined alignment
// (R10) software joins only disabled pairs
// (R11) zero duty with nonzero period gives constant inactive level
// (R12) zero period keeps counter at zero, constant polarity
// (R13) duty at or above period gives constant
// (R14) counters count up after reset
// (R15) channels disabled, counters stopped after reset
// (R16) interrupt only on shutdown when enabled
// (R17) flag on pin change or arming
// (R18) stop or wait: force outputs, no flag
// (R19) block only raises its request
// (R20) joined compare uses same 16-bit rules
module pwm_pair_timer
	import pwm_pkg::*;
#(
	parameter int NCH = 8
) (
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              channel7_pin_i,
	input  wire logic              stop_i,
	input  wire logic              wait_i,
	output logic      [NCH-1:0]    pwm_o,
	output logic      [NCH-1:0]    pwm_active_o,
	output logic                   irq_o
);

	localparam int NP = NCH / 2;
	function automatic logic [NCH-1:0] onehot(input logic [2:0] i);
		onehot = NCH'(1) << i;
	endfunction : onehot

	// one counting step: {direction, count}
	function automatic logic [16:0] step(input logic [15:0] c,
		input logic [15:0] p, input logic d, input logic ctr);
		logic [15:0] inc;
		logic [15:0] dec;
		inc = c + ONE16;
		dec = c - ONE16;
		if (p == ZERO16)
			step = {DIR_UP, ZERO16};
		else if (!ctr)
			step = {DIR_UP, (inc >= p) ? ZERO16 : inc};
		else if (d == DIR_UP)
			step = (c >= p) ? {DIR_DN, dec}
				: {(inc >= p) ? DIR_DN : DIR_UP, inc};
		else
			step = (c <= ONE16) ? {DIR_UP, ZERO16} : {DIR_DN, dec};
	endfunction : step

	function automatic logic level(input logic [15:0] c,
		input logic [15:0] p, input logic [15:0] d, input logic pol);
		if (p == ZERO16)
			level = pol;
		else
			level = ((c < d) || (d >= p)) ? pol : !pol;
	endfunction : level

	apb_req_s          req;
	shdn_ctl_s         sdn;
	logic [NCH-1:0]    chan_en;
	logic [NCH-1:0]    polarity;
	logic [NCH-1:0]    clk_sel;
	logic [NCH-1:0]    align;
	logic [NP-1:0]     pair_join_control;
	logic [7:0]        div_a;
	logic [7:0]        div_b;
	logic [7:0]        pre_a;
	logic [7:0]        pre_b;
	logic              shutdown_flag;
	logic              pin_q;
	logic              sd_en_q;
	logic [7:0]        cnt [NCH];
	logic [7:0]        per [NCH];
	logic [7:0]        dty [NCH];
	logic [NCH-1:0]    dir;
	logic [31:0]       rd_mux;

	assign req = {paddr_i, pwrite_i, pwdata_i};
	// bus decode
	wire [2:0]     grp      = req.addr[GRP_LSB +: 3];
	wire [2:0]     idx      = req.addr[IDX_LSB +: 3];
	wire           bad_hi   = req.addr[ADDR_W-1:8] != '0;
	wire           bad_lo   = req.addr[1:0] != 2'b00;
	wire           ctrl_ok  = (grp == GRP_CTRL) && (idx != 3'h7);
	wire           arr_ok   = grp inside {GRP_CNT, GRP_PER, GRP_DTY};
	wire           jcnt_ok  = (grp == GRP_JCNT) && (idx < 3'(NP));
	wire           mapped   = !bad_hi && !bad_lo
	                          && (ctrl_ok || arr_ok || jcnt_ok);
	wire           access   = psel_i && penable_i;
	wire           wr       = access && req.write && mapped;
	wire [NCH-1:0] idx_hot  = onehot(idx);
	wire           ctrl_wr  = wr && (grp == GRP_CTRL);
	wire [NCH-1:0] cnt_wr   = (wr && grp == GRP_CNT) ? idx_hot : '0;
	wire [NCH-1:0] per_wr   = (wr && grp == GRP_PER) ? idx_hot : '0;
	wire [NCH-1:0] dty_wr   = (wr && grp == GRP_DTY) ? idx_hot : '0;
	wire [NCH-1:0] jcnt_hot = (wr && grp == GRP_JCNT) ? idx_hot : '0;
	wire [NP-1:0]  jcnt_wr  = jcnt_hot[NP-1:0];

	assign pready_o  = access;
	assign pslverr_o = access && !mapped;
	// clock dividers for the two channel clocks
	wire tick_a = (pre_a == div_a);
	wire tick_b = (pre_b == div_b);
	// emergency shutdown
	wire sd_en    = sdn.mod_en && sdn.ch7_en;
	wire pin_act  = (channel7_pin_i == sdn.act_lvl);
	wire force_sd = sd_en && pin_act;                           // R18
	wire quiet    = stop_i || (wait_i && sdn.wait_stop);        // R18
	wire sd_set   = !quiet && sd_en
	                && ((channel7_pin_i != pin_q)
	                || (!sd_en_q && pin_act));                  // R17
	wire flag_clr = ctrl_wr && (idx == C_SHDN) && req.wdata[SD_FLAG];
	assign irq_o  = shutdown_flag && sdn.irq_en;                // R16 R19

	// channel engines
	logic [15:0] e_cnt [NCH];
	logic [15:0] e_per [NCH];
	logic [15:0] e_dty [NCH];
	logic [16:0] e_nxt [NCH];
	logic [7:0]  b_nxt [NCH];
	logic [NCH-1:0] e_run;
	logic [NCH-1:0] e_ld;
	logic [NCH-1:0] b_ld;
	logic [NCH-1:0] active;
	logic [NCH-1:0] wave;

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		localparam int  HI  = c - (c % 2);
		localparam int  LO  = HI + 1;
		localparam bit  ODD = (c % 2) == 1;
		wire joined = pair_join_control[c / 2];                 // R01 R02
		wire wide   = joined && ODD;
		wire upper  = joined && !ODD;
		wire clr    = cnt_wr[c] || (wide && (cnt_wr[HI]
		              || jcnt_wr[c / 2]));                      // R07
		assign active[c] = !upper;                              // R06
		assign e_cnt[c] = wide ? {cnt[HI], cnt[c]}
		                       : {RST_BYTE, cnt[c]};            // R03
		assign e_per[c] = wide ? {per[HI], per[c]}
		                       : {RST_BYTE, per[c]};            // R03
		assign e_dty[c] = wide ? {dty[HI], dty[c]}
		                       : {RST_BYTE, dty[c]};            // R03
		assign e_run[c] = chan_en[c] && active[c]
		                  && (clk_sel[c] ? tick_b : tick_a);    // R04 R06
		assign e_ld[c]  = clr || e_run[c];
		assign e_nxt[c] = clr ? {DIR_UP, ZERO16}
		                  : step(e_cnt[c], e_per[c], dir[c],
		                         align[c]);                     // R09 R20
		assign b_ld[c]  = upper ? e_ld[LO] : e_ld[c];
		assign b_nxt[c] = upper ? e_nxt[LO][15:8]
		                        : e_nxt[c][7:0];
		assign wave[c]  = level(e_cnt[c], e_per[c], e_dty[c],
		                        polarity[c]);                   // R05 R11 R12 R13
	end

	// register write side
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			chan_en           <= '0;                            // R15
			polarity          <= '0;
			clk_sel           <= '0;
			align             <= '0;
			pair_join_control <= '0;
			div_a             <= RST_BYTE;
			div_b             <= RST_BYTE;
			sdn               <= '0;
		end else if (ctrl_wr) begin
			unique case (idx)
				C_ENABLE: chan_en           <= req.wdata[NCH-1:0];
				C_POLAR:  polarity          <= req.wdata[NCH-1:0];
				C_CLKSEL: clk_sel           <= req.wdata[NCH-1:0];
				C_ALIGN:  align             <= req.wdata[NCH-1:0];
				C_JOIN:   pair_join_control <= req.wdata[NP-1:0]; // R02
				C_PRESC: begin
					div_a <= req.wdata[PRE_A +: 8];
					div_b <= req.wdata[PRE_B +: 8];
				end
				C_SHDN: begin
					sdn.irq_en    <= req.wdata[SD_IE];
					sdn.ch7_en    <= req.wdata[SD_CH7EN];
					sdn.act_lvl   <= req.wdata[SD_ACT];
					sdn.mod_en    <= req.wdata[SD_MODEN];
					sdn.wait_stop <= req.wdata[SD_WSTOP];
					sdn.level     <= req.wdata[SD_LVL +: 8];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_i) begin
				per[c] <= RST_BYTE;
				dty[c] <= RST_BYTE;
			end else begin
				if (per_wr[c])
					per[c] <= req.wdata[7:0];
				if (dty_wr[c])
					dty[c] <= req.wdata[7:0];
			end
		end
	end

	// counters and direction
	always_ff @(posedge clock_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_i) begin
				cnt[c] <= RST_BYTE;
				dir[c] <= DIR_UP;                               // R14
			end else begin
				if (b_ld[c])
					cnt[c] <= b_nxt[c];
				if (e_ld[c])
					dir[c] <= e_nxt[c][16];
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pre_a <= RST_BYTE;
			pre_b <= RST_BYTE;
		end else begin
			pre_a <= tick_a ? RST_BYTE : pre_a + 8'h01;
			pre_b <= tick_b ? RST_BYTE : pre_b + 8'h01;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			shutdown_flag <= 1'b0;
			pin_q         <= 1'b0;
			sd_en_q       <= 1'b0;
		end else begin
			shutdown_flag <= sd_set || (shutdown_flag && !flag_clr); // R17
			pin_q         <= channel7_pin_i;
			sd_en_q       <= sd_en;
		end
	end

	// pin outputs
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pwm_o        <= '0;
			pwm_active_o <= '0;
		end else begin
			pwm_active_o <= chan_en & active;                   // R06
			for (int c = 0; c < NCH; c++)
				pwm_o[c] <= force_sd ? sdn.level[c]
				            : (chan_en[c] && active[c] && wave[c]); // R05 R18
		end
	end

	// read side, captured in the setup cycle
	always_comb begin
		rd_mux = '0;
		unique case (grp)
			GRP_CTRL: begin
				unique case (idx)
					C_ENABLE: rd_mux[NCH-1:0] = chan_en;
					C_POLAR:  rd_mux[NCH-1:0] = polarity;
					C_CLKSEL: rd_mux[NCH-1:0] = clk_sel;
					C_ALIGN:  rd_mux[NCH-1:0] = align;
					C_JOIN:   rd_mux[NP-1:0]  = pair_join_control;
					C_PRESC:  rd_mux[15:0]    = {div_b, div_a};
					C_SHDN: begin
						rd_mux[SD_IE]        = sdn.irq_en;
						rd_mux[SD_FLAG]      = shutdown_flag;
						rd_mux[SD_CH7EN]     = sdn.ch7_en;
						rd_mux[SD_ACT]       = sdn.act_lvl;
						rd_mux[SD_MODEN]     = sdn.mod_en;
						rd_mux[SD_WSTOP]     = sdn.wait_stop;
						rd_mux[SD_PIN]       = channel7_pin_i;
						rd_mux[SD_LVL +: 8]  = sdn.level;
					end
					default: ;
				endcase
			end
			GRP_CNT:  rd_mux[7:0]  = cnt[idx];
			GRP_PER:  rd_mux[7:0]  = per[idx];
			GRP_DTY:  rd_mux[7:0]  = dty[idx];
			GRP_JCNT: rd_mux[15:0] = {cnt[{idx[1:0], 1'b0}],
			                          cnt[{idx[1:0], 1'b1}]};   // R08
			default: ;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i)
			prdata_o <= '0;
		else if (psel_i && !penable_i)
			prdata_o <= mapped ? rd_mux : '0;
	end

	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	a_reset_idle: assert property ($fell(rst_i) |->           // R14
		chan_en == '0 && dir == '0 && cnt[0] == RST_BYTE)
		else $error("channels not idle after reset");
	a_irq_on_set: assert property (sd_set && sdn.irq_en          // R16
		&& !(ctrl_wr && idx == C_SHDN) |=> irq_o)
		else $error("shutdown did not raise interrupt");
	a_quiet_noflag: assert property (quiet && !shutdown_flag     // R18
		|=> !shutdown_flag)
		else $error("flag set while quiet");
	a_force_level: assert property (force_sd |=>                 // R18
		pwm_o == $past(sdn.level))
		else $error("shutdown level not forced");
	a_pin_change: assert property (sd_en && !quiet              // R17
		&& channel7_pin_i != pin_q |=> shutdown_flag)
		else $error("pin change missed");
	a_upper_off: assert property (pair_join_control[0]          // R06
		|=> !pwm_active_o[0] && !pwm_o[0] || $past(force_sd))
		else $error("upper output not disabled");
	a_duty_zero: assert property (!pair_join_control[1]          // R11
		&& chan_en[2] && per[2] != RST_BYTE && dty[2] == RST_BYTE
		&& !force_sd |=> pwm_o[2] == !$past(polarity[2]))
		else $error("zero duty not constant");
	a_per_zero: assert property (!pair_join_control[1]           // R12
		&& chan_en[2] && per[2] == RST_BYTE && !force_sd
		|=> pwm_o[2] == $past(polarity[2]))
		else $error("zero period not constant");
	a_duty_full: assert property (!pair_join_control[1]          // R13
		&& chan_en[2] && dty[2] >= per[2] && !force_sd
		|=> pwm_o[2] == $past(polarity[2]))
		else $error("full duty not constant");
	a_join_clear: assert property (pair_join_control[0]          // R07
		&& (cnt_wr[0] || cnt_wr[1] || jcnt_wr[0])
		|=> cnt[0] == RST_BYTE && cnt[1] == RST_BYTE)
		else $error("joined counter not cleared");
	a_join_wrap: assert property (pair_join_control[0]           // R20
		&& e_run[1] && !e_nxt[1][16] && !align[1]
		&& e_cnt[1] + ONE16 >= e_per[1] && !cnt_wr[1]
		&& !cnt_wr[0] && !jcnt_wr[0]
		|=> {cnt[0], cnt[1]} == ZERO16)
		else $error("joined counter did not wrap");
	a_stop_hold: assert property (!chan_en[0] && !cnt_wr[0]       // R15
		&& !pair_join_control[0] |=> cnt[0] == $past(cnt[0]))
		else $error("disabled counter moved");

	c_join_run: cover property (pair_join_control[0] && e_run[1]
		&& e_cnt[1] > 16'h00FF);
	c_center_turn: cover property (align[3] && e_run[3]
		&& dir[3] == DIR_UP ##1 dir[3] == DIR_DN);
	c_flag_set: cover property (sd_set ##1 irq_o);
	c_bus_error: cover property (pslverr_o);

endmodule : pwm_pair_timer

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb
	import pwm_pkg::*;
;
	logic              clock_i    = 1'b0;
	logic              rst_i      = 1'b1;
	logic              psel       = 1'b0;
	logic              penable    = 1'b0;
	logic              pwrite     = 1'b0;
	logic [ADDR_W-1:0] paddr      = 12'h000;
	logic [31:0]       pwdata     = 32'h0;
	logic              pin7       = 1'b0;
	logic              lp_stop    = 1'b0;
	logic              lp_wait    = 1'b0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              irq;
	logic [7:0]        pwm;
	logic [7:0]        act;
	logic [31:0]       rd;
	logic              err;
	int                err_total  = 0;
	int                n_compared = 0;
	int                hi;
	logic [7:0]        bper [6]   = '{8'h04, 8'h04, 8'h00, 8'h00, 8'h04, 8'h04};
	logic [7:0]        bdty [6]   = '{8'h00, 8'h00, 8'h05, 8'h05, 8'h04, 8'h06};
	logic [7:0]        bpol [6]   = '{8'h04, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00};
	logic [31:0]       bexp [6]   = '{32'h0, 32'h10, 32'h10, 32'h0, 32'h10, 32'h0};

	always #5 clock_i = ~clock_i;

	pwm_pair_timer u_pwm_pair_timer (
		.clock_i        (clock_i),
		.rst_i          (rst_i),
		.psel_i         (psel),
		.penable_i      (penable),
		.pwrite_i       (pwrite),
		.paddr_i        (paddr),
		.pwdata_i       (pwdata),
		.prdata_o       (prdata),
		.pready_o       (pready),
		.pslverr_o      (pslverr),
		.channel7_pin_i (pin7),
		.stop_i         (lp_stop),
		.wait_i         (lp_wait),
		.pwm_o          (pwm),
		.pwm_active_o   (act),
		.irq_o          (irq)
	);

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {4'h0, a};
		pwdata  <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do begin
			@(posedge clock_i);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask : rdm

	task cnt_hi(input int ch, input int n);
		hi = 0;
		repeat (n) begin
			@(negedge clock_i);
			hi += int'(pwm[ch]);
		end
	endtask : cnt_hi

	task settle;
		repeat (4) @(posedge clock_i);
		@(negedge clock_i);
	endtask : settle

	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	initial begin
		#100000;
		err_total++;
		stop_test();
	end

	initial begin
		repeat (5) @(posedge clock_i);
		rst_i <= 1'b0;
		settle();
		chk({16'h0, pwm, act}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rdm(8'h00, 32'hFFFFFFFF, 32'h0);
		rdm(8'h20, 32'hFFFFFFFF, 32'h0);
		// unmapped address
		apb(1'b0, 8'hFC, 32'h0);
		chk({31'h0, err}, 32'h1);
		// plain channels: ch0 left, ch3 center
		wr(8'h40, 32'h04);
		wr(8'h4C, 32'h04);
		wr(8'h60, 32'h01);
		wr(8'h6C, 32'h01);
		wr(8'h0C, 32'h08);
		wr(8'h04, 32'h09);
		wr(8'h00, 32'h0D);
		cnt_hi(0, 40);
		chk(32'(hi), 32'h0A);
		cnt_hi(3, 80);
		chk(32'(hi), 32'h0A);
		// boundary table on ch2
		for (int i = 0; i < 6; i++) begin
			wr(8'h48, {24'h0, bper[i]});
			wr(8'h68, {24'h0, bdty[i]});
			wr(8'h04, {24'h0, bpol[i] | 8'h09});
			wr(8'h28, 32'h0);
			settle();
			cnt_hi(2, 16);
			chk(32'(hi), bexp[i]);
			if (bper[i] == 8'h00) begin
				rdm(8'h28, 32'hFF, 32'h0);
			end
		end
		// pair 0/1 joined, clock B divided by two
		wr(8'h00, 32'h0);
		wr(8'h10, 32'h01);
		wr(8'h40, 32'h00);
		wr(8'h44, 32'h04);
		wr(8'h60, 32'h00);
		wr(8'h64, 32'h01);
		wr(8'h04, 32'h02);
		wr(8'h08, 32'h02);
		wr(8'h14, 32'h0100);
		wr(8'h0C, 32'h01);
		wr(8'h80, 32'h0);
		wr(8'h00, 32'h01);
		settle();
		chk({30'h0, act[1:0]}, 32'h0);
		chk({30'h0, pwm[1:0]}, 32'h0);
		wr(8'h00, 32'h02);
		settle();
		chk({30'h0, act[1:0]}, 32'h2);
		cnt_hi(1, 80);
		chk(32'(hi), 32'h14);
		chk({31'h0, pwm[0]}, 32'h0);
		wr(8'h60, 32'h01);
		settle();
		cnt_hi(1, 40);
		chk(32'(hi), 32'h28);
		wr(8'h40, 32'h02);
		wr(8'h44, 32'h00);
		wr(8'h80, 32'h0);
		repeat (600) @(posedge clock_i);
		wr(8'h00, 32'h0);
		rdm(8'h80, 32'hFF00, 32'h0100);
		wr(8'h20, 32'h55);
		rdm(8'h80, 32'hFFFFFFFF, 32'h0);
		// shutdown, level byte A5, active high
		wr(8'h18, 32'hA51D);
		@(posedge clock_i) pin7 <= 1'b1;
		settle();
		chk({31'h0, irq}, 32'h1);
		chk({24'h0, pwm}, 32'hA5);
		wr(8'h18, 32'hA51E);
		rdm(8'h18, 32'h2, 32'h0);
		@(posedge clock_i) pin7 <= 1'b0;
		settle();
		chk({31'h0, irq}, 32'h0);
		rdm(8'h18, 32'h2, 32'h2);
		wr(8'h18, 32'hA51E);
		@(posedge clock_i) lp_stop <= 1'b1;
		pin7 <= 1'b1;
		settle();
		chk({24'h0, pwm}, 32'hA5);
		rdm(8'h18, 32'h2, 32'h0);
		lp_stop <= 1'b0;
		wr(8'h18, 32'hA53E);
		@(posedge clock_i) lp_wait <= 1'b1;
		pin7 <= 1'b0;
		settle();
		rdm(8'h18, 32'h2, 32'h0);
		lp_wait <= 1'b0;
		wr(8'h18, 32'hA51B);
		@(posedge clock_i) pin7 <= 1'b1;
		settle();
		chk({31'h0, irq}, 32'h0);
		wr(8'h18, 32'hA51D);
		settle();
		chk({31'h0, irq}, 32'h1);
		stop_test();
	end

endmodule : tb
